/* File: bench/ddr_memory_phy_datapath_tb.sv */
// Self-checking bench for the DDR memory physical datapath.
`timescale 1ns/1ps
module ddr_memory_phy_datapath_tb;
  import dmpd_pkg::*;
  localparam int G = 2;
  localparam bit E = 1'b1;
  localparam int L = G + 1;
  localparam int W = L * LANE_BITS;
  localparam int RW = 40;
  logic clk_sys, arst_n, modeSeparate, modeReadClock, phaseSel72;
  logic wrValid, wrReady, cmdValid, cmdWrite, cmdAccept, rdDone;
  logic rdValid, rdTimeout, memClk, memClkN, memWriteClock, memWriteClockN;
  logic memStrobeOut, memStrobeOe, strobeComplementOut, strobeComplementOe;
  logic strobeIn, mdlStrobe, hostReadValidIn, slow, silent;
  logic [W-1:0] wrRise, wrFall, rdRise, rdFall, memDataOut, memWrData;
  logic [W-1:0] dataIn, mdlData, riseWord, fallWord;
  logic [L-1:0] wrMaskRise, wrMaskFall, memDataOe, memMask;
  logic [CMD_W-1:0] memCmd;
  logic [12:0] cmdAddr, memAddr;
  int num_errors = 0;
  int num_checks = 0;

  dmpd_top #(.GROUPS(G), .ECC_EN(E), .READ_WAIT(RW)) uut (.clk_sys, .arst_n,
    .modeSeparate, .modeReadClock, .phaseSel72, .wrValid, .wrReady, .wrRise,
    .wrFall, .wrMaskRise, .wrMaskFall, .cmdValid, .cmdWrite, .cmdAddr,
    .cmdAccept, .rdValid, .rdRise, .rdFall, .rdTimeout, .memClk, .memClkN,
    .memWriteClock, .memWriteClockN, .memCmd, .memAddr, .memStrobeOut,
    .memStrobeOe, .strobeComplementOut, .strobeComplementOe,
    .memStrobeIn(strobeIn), .memDataOut, .memDataOe, .memDataIn(dataIn),
    .memWrData, .memMask, .hostReadValidIn);
  dmpd_mem_model #(.W(W)) u_mem (.memCmd, .modeReadClock, .slow, .silent,
    .riseWord, .fallWord, .memStrobeIn(mdlStrobe), .memDataIn(mdlData),
    .hostReadValidIn);

  // Shared pins: whoever enables its driver sets the wire level.
  assign strobeIn = memStrobeOe ? memStrobeOut : mdlStrobe;
  for (genvar g = 0; g < L; g++) begin : g_lane
    assign dataIn[g*8 +: 8] = memDataOe[g] ? memDataOut[g*8 +: 8]
      : mdlData[g*8 +: 8];
  end
  always_comb rdDone = rdValid | rdTimeout;

  // System clock of 40 ns.
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    if (num_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  // Waits for a flag at rising edges, bounded so a hang is reported.
  task automatic hs(ref logic s);
    int i;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (s !== 1'b1 && i < 80);
    if (s !== 1'b1) begin
      num_errors++;
      $display("[ERR] %0t: handshake never came", $time);
    end
  endtask : hs

  task automatic push(input logic [W-1:0] r, f, input logic [L-1:0] mr, mf);
    @(negedge clk_sys);
    wrValid = 1'b1;
    wrRise = r;
    wrFall = f;
    wrMaskRise = mr;
    wrMaskFall = mf;
    hs(wrReady);
    @(negedge clk_sys);
    wrValid = 1'b0;
  endtask : push

  task automatic cmd(input logic wr, input logic [12:0] a);
    @(negedge clk_sys);
    cmdValid = 1'b1;
    cmdWrite = wr;
    cmdAddr = a;
    hs(cmdAccept);
    check(memCmd, wr ? CMD_WRITE : CMD_READ);
    check(memAddr, a);
    @(negedge clk_sys);
    cmdValid = 1'b0;
  endtask : cmd

  // One write; words and masks checked at both strobe edges.
  task automatic t_write(input logic sep, input logic [W-1:0] r, f,
    input logic [L-1:0] mr, mf);
    @(negedge clk_sys);
    modeSeparate = sep;
    push(r, f, mr, mf);
    cmd(1'b1, 13'h0A5);
    hs(memStrobeOut);
    check(sep ? memWrData : memDataOut, r);
    check(memMask, mr);
    check(memDataOe, {L{~sep}});
    check(memStrobeOe, 1'b1);
    check(strobeComplementOut, 1'b0);
    check(memWriteClock, 1'b1);
    repeat (4) @(posedge clk_sys);
    check(memStrobeOut, 1'b0);
    check(memWriteClockN, 1'b1);
    check(sep ? memWrData : memDataOut, f);
    check(memMask, mf);
    repeat (8) @(posedge clk_sys);
  endtask : t_write

  // Two entries fill the buffer while no command drains it.
  task automatic t_fill();
    push({3{8'h11}}, {3{8'h22}}, 3'h0, 3'h0);
    push({3{8'h33}}, {3{8'h44}}, 3'h0, 3'h0);
    check(wrReady, 1'b0);
    cmd(1'b1, 13'h001);
    cmd(1'b1, 13'h002);
    repeat (12) @(posedge clk_sys);
    check(wrReady, 1'b1);
  endtask : t_fill

  // A read in either strobe mode and shift, prompt, slow or unanswered.
  task automatic t_read(input logic rclk, sel72, slw, sil);
    @(negedge clk_sys);
    modeReadClock = rclk;
    phaseSel72 = sel72;
    slow = slw;
    silent = sil;
    riseWord = {8'h5A, 8'hC3, 4'h0, rclk, sel72, slw, 1'b1};
    fallWord = ~riseWord;
    cmd(1'b0, 13'h1F0);
    hs(rdDone);
    check(rdTimeout, sil);
    check(rdValid, !sil);
    if (!sil) begin
      check(rdRise, riseWord);
      check(rdFall, fallWord);
    end
    repeat (16) @(posedge clk_sys);
  endtask : t_read

  // Main sequence; inputs move on falling edges only.
  initial begin
    arst_n = 1'b0;
    {modeSeparate, modeReadClock, phaseSel72, wrValid, cmdValid} = '0;
    {cmdWrite, slow, silent} = '0;
    {wrRise, wrFall, wrMaskRise, wrMaskFall, cmdAddr} = '0;
    {riseWord, fallWord} = '0;
    repeat (2) @(posedge clk_sys);
    check(memCmd, CMD_NOP);
    check(memClkN, 1'b1);
    check(memDataOe, '0);
    @(negedge clk_sys);
    arst_n = 1'b1;
    t_write(1'b0, 24'h3C5AA5, 24'hC3A55A, 3'h5, 3'h2);
    t_write(1'b1, 24'h0F1E2D, 24'hF0E1D2, 3'h2, 3'h4);
    t_fill();
    t_read(1'b0, 1'b0, 1'b0, 1'b0);
    t_read(1'b0, 1'b1, 1'b1, 1'b0);
    t_read(1'b0, 1'b0, 1'b0, 1'b1);
    t_read(1'b1, 1'b0, 1'b1, 1'b0);
    t_read(1'b1, 1'b1, 1'b0, 1'b0);
    wrap_up();
  end

  // Watchdog at 10000 cycles, well beyond the few hundred cycles the tests need.
  initial begin
    #400000;
    num_errors++;
    wrap_up();
  end
endmodule : ddr_memory_phy_datapath_tb

/* File: bench/dmpd_mem_model.sv */
// Behavioural memory chip answering reads with a strobe and a word pair.
`timescale 1ns/1ps
module dmpd_mem_model #(
  parameter int W = 16
) (
  // Command pins and bench controls.
  input wire logic [dmpd_pkg::CMD_W-1:0] memCmd,
  input wire logic modeReadClock,
  input wire logic slow,
  input wire logic silent,
  input wire logic [W-1:0] riseWord,
  input wire logic [W-1:0] fallWord,
  // Pins driven back to the datapath.
  output logic memStrobeIn,
  output logic [W-1:0] memDataIn,
  output logic hostReadValidIn
);
  import dmpd_pkg::*;
  int pending = 0;
  logic go;
  // A read arms one burst; a slow answer lets one lap pass first.
  always @(memCmd) begin
    if (memCmd === CMD_READ && !silent) begin
      pending = slow ? 2 : 1;
    end
  end
  // Laps of 320 ns; the strobe stands still outside a burst unless the
  // read clock runs free, and idle data shows the inverse of its last value.
  initial begin
    memStrobeIn = 1'b0;
    memDataIn = '0;
    hostReadValidIn = 1'b0;
    #13;
    forever begin
      go = (pending == 1);
      if (pending > 0) begin
        pending--;
      end
      hostReadValidIn = go;
      memStrobeIn = go || modeReadClock;
      memDataIn = go ? riseWord : ~memDataIn;
      #160;
      memStrobeIn = 1'b0;
      memDataIn = go ? fallWord : ~memDataIn;
      #160;
    end
  end
endmodule : dmpd_mem_model

/* File: bench/dmpd_top_asserts.sv */
// Concurrent checks on the ports of the DDR memory datapath.
`timescale 1ns/1ps
module dmpd_top_asserts #(
  parameter int GROUPS = 2,
  parameter bit ECC_EN = 1'b0,
  parameter int READ_WAIT = 40
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Modes and handshakes.
  input wire logic modeSeparate,
  input wire logic modeReadClock,
  input wire logic cmdWrite,
  input wire logic cmdAccept,
  input wire logic rdValid,
  input wire logic rdTimeout,
  // Memory pins.
  input wire logic memClk,
  input wire logic memClkN,
  input wire logic [dmpd_pkg::CMD_W-1:0] memCmd,
  input wire logic memStrobeOut,
  input wire logic memStrobeOe,
  input wire logic strobeComplementOe,
  input wire logic [GROUPS+ECC_EN-1:0] memDataOe,
  input wire logic [(GROUPS+ECC_EN)*dmpd_pkg::LANE_BITS-1:0] memDataOut,
  input wire logic [(GROUPS+ECC_EN)*dmpd_pkg::LANE_BITS-1:0] memWrData
);
  import dmpd_pkg::*;
  // Slack of a few cycles covers the result register after the wait.
  localparam int WAIT_MAX = READ_WAIT + 4;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // One memory clock lap: four cycles high, four low, pair opposite.
  sequence s_clk_lap;
    (memClk && !memClkN)[*4] ##1 (!memClk && memClkN)[*4] ##1 memClk;
  endsequence
  // The command and its hold over the rest of the lap.
  sequence s_cmd_held(logic [1:0] code);
    memCmd == code ##1 $stable(memCmd)[*7];
  endsequence
  a_cmd_on_fall: assert property (@(negedge clk_sys)
    $rose(cmdAccept) |-> memCmd == CMD_NOP ##1 memCmd != CMD_NOP)
    else $error("command not launched on the falling edge");
  a_cmd_kind: assert property (
    cmdAccept |-> s_cmd_held($past(cmdWrite) ? CMD_WRITE : CMD_READ))
    else $error("command code wrong or not held for a lap");
  a_read_quiet: assert property (
    cmdAccept && memCmd == CMD_READ |-> (memDataOe == '0 && !memStrobeOe
    && !strobeComplementOe)[*8]) else $error("pins driven during a read");
  a_rclk_oe_off: assert property (
    modeReadClock |-> !memStrobeOe && !strobeComplementOe)
    else $error("strobe enable active in read clock mode");
  a_sep_no_dq: assert property (
    modeSeparate |-> memDataOe == '0)
    else $error("shared data pins driven in separate mode");
  a_clk_lap: assert property ($rose(memClk) |-> s_clk_lap)
    else $error("memory clock pair shape wrong");
  a_strobe_align: assert property (
    $rose(memStrobeOut) && memStrobeOe |-> $rose(memClk))
    else $error("write strobe not aligned to memory clock");
  a_data_centred: assert property (
    memStrobeOe && ($rose(memStrobeOut) || $fell(memStrobeOut)) |->
    $stable(memWrData) && memDataOut == $past(memDataOut, 2))
    else $error("write data moved near a strobe edge");
  a_read_ends: assert property (
    cmdAccept && memCmd == CMD_READ |-> ##[1:WAIT_MAX] (rdValid || rdTimeout))
    else $error("read gave neither data nor timeout");
endmodule : dmpd_top_asserts

bind dmpd_top dmpd_top_asserts #(.GROUPS(GROUPS), .ECC_EN(ECC_EN),
  .READ_WAIT(READ_WAIT)) u_asserts (.clk_sys, .arst_n, .modeSeparate,
  .modeReadClock, .cmdWrite, .cmdAccept, .rdValid, .rdTimeout, .memClk,
  .memClkN, .memCmd, .memStrobeOut, .memStrobeOe, .strobeComplementOe,
  .memDataOe, .memDataOut, .memWrData);

/* File: core/dmpd_cap_if.sv */
// Signals between the sequencer and the read capture stage.
`timescale 1ns/1ps
interface dmpd_cap_if #(parameter int WIDTH = 16);
  logic strobeSync;
  logic [WIDTH-1:0] dataSync;
  logic validSync;
  logic sel72;
  logic [WIDTH-1:0] riseWord;
  logic [WIDTH-1:0] fallWord;
  logic pairValid;
  logic pairQual;
  modport core (output strobeSync, dataSync, validSync, sel72,
    input riseWord, fallWord, pairValid, pairQual);
  modport cap (input strobeSync, dataSync, validSync, sel72,
    output riseWord, fallWord, pairValid, pairQual);
endinterface : dmpd_cap_if

/* File: core/dmpd_capture.sv */
// Read capture: strobe shift, inversion, two-word capture and resync.
`timescale 1ns/1ps
module dmpd_capture (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Link to the sequencer.
  dmpd_cap_if.cap cap
);
  import dmpd_pkg::*;
  localparam int W = $bits(cap.riseWord);

  if (SHIFT72_CYC > SHIFT90_CYC) begin : g_chk
    $error("dmpd_capture shift choices are out of order.");
  end

  logic [SHIFT90_CYC-1:0] dlyReg;
  logic shifted;
  logic invShift;
  logic invPrevReg;
  logic [W-1:0] riseCapReg;
  logic [W-1:0] fallCapReg;
  logic fallSeenReg;
  logic qualReg;

  // The shift centres an edge-aligned strobe on the data eye.
  assign shifted = cap.sel72 ? dlyReg[SHIFT72_CYC-1] :
    dlyReg[SHIFT90_CYC-1];
  // The capture stage works on the inverted shifted strobe.
  assign invShift = ~shifted;

  // Delay line and edge memory of the inverted strobe.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dlyReg <= '0;
      invPrevReg <= 1'b1;
    end else begin
      dlyReg <= SHIFT90_CYC'({dlyReg, cap.strobeSync});
      invPrevReg <= invShift;
    end
  end

  // A falling inverted edge takes the rising word, a rising one the other.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      riseCapReg <= '0;
      fallCapReg <= '0;
      fallSeenReg <= 1'b0;
      qualReg <= 1'b0;
    end else begin
      fallSeenReg <= 1'b0;
      if (invPrevReg && !invShift) begin
        riseCapReg <= cap.dataSync;
      end
      if (!invPrevReg && invShift) begin
        fallCapReg <= cap.dataSync;
        fallSeenReg <= 1'b1;
        qualReg <= cap.validSync;
      end
    end
  end

  // Both words pass one more system clock register before use.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cap.riseWord <= '0;
      cap.fallWord <= '0;
      cap.pairValid <= 1'b0;
      cap.pairQual <= 1'b0;
    end else begin
      cap.riseWord <= riseCapReg;
      cap.fallWord <= fallCapReg;
      cap.pairValid <= fallSeenReg;
      cap.pairQual <= qualReg;
    end
  end
endmodule : dmpd_capture

/* File: core/dmpd_fifo2.sv */
// Small buffer with valid and ready on both sides.
`timescale 1ns/1ps
module dmpd_fifo2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Filling side.
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Draining side.
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

  // Pointers wrap naturally, so the depth must be a power of two.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("dmpd_fifo2 depth must be a power of two of at least 2.");
  end

  logic [WIDTH-1:0] memReg [DEPTH];
  logic [PTR_W-1:0] wrPtrReg;
  logic [PTR_W-1:0] rdPtrReg;
  logic [CNT_W-1:0] cntReg;
  logic [CNT_W-1:0] cntNext;
  logic push;
  logic pop;

  // Handshakes use the registered flags, so full and empty are honest.
  assign push = inValid & inReady;
  assign pop = outValid & outReady;
  assign outData = memReg[rdPtrReg];

  always_comb begin
    cntNext = cntReg;
    if (push && !pop) begin
      cntNext = cntReg + CNT_W'(1);
    end else if (pop && !push) begin
      cntNext = cntReg - CNT_W'(1);
    end
  end

  // Storage is written without reset; only valid entries are ever read.
  always_ff @(posedge clk_sys) begin
    if (push) begin
      memReg[wrPtrReg] <= inData;
    end
  end

  // Pointers, fill level and the registered flags.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wrPtrReg <= '0;
      rdPtrReg <= '0;
      cntReg <= '0;
      inReady <= 1'b0;
      outValid <= 1'b0;
    end else begin
      wrPtrReg <= wrPtrReg + PTR_W'(push);
      rdPtrReg <= rdPtrReg + PTR_W'(pop);
      cntReg <= cntNext;
      inReady <= (cntNext != FULL_CNT);
      outValid <= (cntNext != '0);
    end
  end
endmodule : dmpd_fifo2

/* File: core/dmpd_pkg.sv */
// Shared constants and types for the DDR memory physical datapath.
package dmpd_pkg;
  // Clock rates; the memory clock is made from the system clock.
  localparam int SYS_CLK_NS = 40;
  localparam int MEM_CLK_NS = 320;
  localparam int MEM_CYC = MEM_CLK_NS / SYS_CLK_NS;
  localparam int HALF_CYC = MEM_CYC / 2;
  localparam int QUART_CYC = MEM_CYC / 4;
  // Read strobe shift in degrees of the memory clock, rounded down.
  localparam int SHIFT72_DEG = 72;
  localparam int SHIFT90_DEG = 90;
  localparam int SHIFT72_RAW = MEM_CYC * SHIFT72_DEG / 360;
  localparam int SHIFT90_RAW = MEM_CYC * SHIFT90_DEG / 360;
  localparam int SHIFT72_CYC = (SHIFT72_RAW < 1) ? 1 : SHIFT72_RAW;
  localparam int SHIFT90_CYC = (SHIFT90_RAW < 1) ? 1 : SHIFT90_RAW;
  // Longest wait for read data after a read command.
  localparam int READ_WAIT_NS = 2560;
  localparam int READ_WAIT_CYC = READ_WAIT_NS / SYS_CLK_NS;
  localparam int WAIT_W = $clog2(READ_WAIT_CYC + 1);
  // Data lines per group; the single strobe serves all groups.
  localparam int LANE_BITS = 8;
  // Phase points inside one memory clock period.
  localparam int PH_W = $clog2(MEM_CYC);
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(MEM_CYC - 1);
  localparam logic [PH_W-1:0] PH_RISE = PH_W'(MEM_CYC - QUART_CYC);
  localparam logic [PH_W-1:0] PH_FALL = PH_W'(HALF_CYC - QUART_CYC);
  localparam logic [PH_W-1:0] PH_CMD = PH_W'(MEM_CYC - QUART_CYC - 1);
  localparam logic [PH_W-1:0] PH_HALF = PH_W'(HALF_CYC);
  // Command codes on the memory command pins.
  localparam int CMD_W = 2;
  localparam logic [CMD_W-1:0] CMD_NOP = 2'h0;
  localparam logic [CMD_W-1:0] CMD_READ = 2'h1;
  localparam logic [CMD_W-1:0] CMD_WRITE = 2'h2;
  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WRITE = 3'h2,
    ST_READ = 3'h4
  } dmpd_state_t;
endpackage : dmpd_pkg

/* File: core/dmpd_top.sv */
// Physical datapath between the core logic and external DDR memory.
// Notes on behaviour
// - Data on both edges, commands on one.
// - Active-high write mask, one per group.
// - One strobe shared by all eight-line groups.
// - Optional extra group carries check bits.
// - Commands launched from falling system edge.
// - Memory clock from registers, strobe edge aligned.
// - Incoming strobe shifted onto data eye centre.
// - Strobe on clock, data a quarter earlier.
// - Write strobe centred in the data eye.
// - Read shift selectable, 72 or 90 degrees.
// - Shifted strobe inverted before capture.
// - Both captured words resynced on system clock.
// - Common or separate data pins supported.
// - Read clock mode: strobe enables held off.
// - Capture with shifted, inverted read clock.
// - Read-valid input qualifies read data in read clock mode.
// - Reads edge-aligned in, writes centred out.
`timescale 1ns/1ps
module dmpd_top #(
  parameter int GROUPS = 2,
  parameter bit ECC_EN = 1'b0,
  parameter int ADDR_W = 13,
  parameter int READ_WAIT = dmpd_pkg::READ_WAIT_CYC
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Configuration, steady while traffic runs.
  input wire logic modeSeparate,
  input wire logic modeReadClock,
  input wire logic phaseSel72,
  // Write data entry, one word pair per memory clock.
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [(GROUPS+ECC_EN)*dmpd_pkg::LANE_BITS-1:0] wrRise,
  input wire logic [(GROUPS+ECC_EN)*dmpd_pkg::LANE_BITS-1:0] wrFall,
  input wire logic [GROUPS+ECC_EN-1:0] wrMaskRise,
  input wire logic [GROUPS+ECC_EN-1:0] wrMaskFall,
  // Command entry.
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [ADDR_W-1:0] cmdAddr,
  output logic cmdAccept,
  // Read result.
  output logic rdValid,
  output logic [(GROUPS+ECC_EN)*dmpd_pkg::LANE_BITS-1:0] rdRise,
  output logic [(GROUPS+ECC_EN)*dmpd_pkg::LANE_BITS-1:0] rdFall,
  output logic rdTimeout,
  // Memory clocks.
  output logic memClk,
  output logic memClkN,
  output logic memWriteClock,
  output logic memWriteClockN,
  // Memory command and address.
  output logic [dmpd_pkg::CMD_W-1:0] memCmd,
  output logic [ADDR_W-1:0] memAddr,
  // Strobe or read clock pins, both polarities.
  output logic memStrobeOut,
  output logic memStrobeOe,
  output logic strobeComplementOut,
  output logic strobeComplementOe,
  input wire logic memStrobeIn,
  // Data pins.
  output logic [(GROUPS+ECC_EN)*dmpd_pkg::LANE_BITS-1:0] memDataOut,
  output logic [GROUPS+ECC_EN-1:0] memDataOe,
  input wire logic [(GROUPS+ECC_EN)*dmpd_pkg::LANE_BITS-1:0] memDataIn,
  output logic [(GROUPS+ECC_EN)*dmpd_pkg::LANE_BITS-1:0] memWrData,
  output logic [GROUPS+ECC_EN-1:0] memMask,
  input wire logic hostReadValidIn
);
  import dmpd_pkg::*;

  // Lane count includes the check-bit group when it is present.
  localparam int LANES = GROUPS + int'(ECC_EN);
  localparam int W = LANES * LANE_BITS;
  localparam int BUF_W = 2 * W + 2 * LANES;
  localparam int SYNC_W = W + 2;

  // Only whole eight-bit strobe groups of one, two or four are served.
  if (GROUPS != 1 && GROUPS != 2 && GROUPS != 4) begin : g_chk_grp
    $error("dmpd_top serves one, two or four strobe groups.");
  end
  if (READ_WAIT < 1 || READ_WAIT >= (1 << WAIT_W)) begin : g_chk_wait
    $error("dmpd_top read wait does not fit its counter.");
  end
  if (MEM_CYC < 4 || (MEM_CYC % 4) != 0) begin : g_chk_cyc
    $error("dmpd_top memory clock must be four system cycles or more.");
  end

  dmpd_state_t stateReg;
  dmpd_state_t stateNext;
  logic [PH_W-1:0] phReg;
  logic [PH_W-1:0] phNext;
  logic clkLevelNext;
  logic [SYNC_W-1:0] syncAReg;
  logic [SYNC_W-1:0] syncBReg;
  logic bufValid;
  logic bufReady;
  logic [BUF_W-1:0] bufData;
  logic [BUF_W-1:0] bufIn;
  logic takeWrite;
  logic takeRead;
  logic [W-1:0] beatRiseReg;
  logic [W-1:0] beatFallReg;
  logic [LANES-1:0] maskRiseReg;
  logic [LANES-1:0] maskFallReg;
  logic launchedReg;
  logic writeDone;
  logic [WAIT_W-1:0] waitReg;
  logic readHit;
  logic readLate;
  logic [CMD_W-1:0] cmdStageReg;
  logic [ADDR_W-1:0] addrStageReg;

  dmpd_cap_if #(.WIDTH(W)) capLink ();

  // Buffer entry layout: rising word, falling word, then both masks.
  assign bufIn = {wrRise, wrFall, wrMaskRise, wrMaskFall};

  // A stalled write sequencer leaves the buffer full and drops wrReady.
  dmpd_fifo2 #(
    .WIDTH(BUF_W),
    .DEPTH(2)
  ) u_wrbuf (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .inValid(wrValid),
    .inReady(wrReady),
    .inData(bufIn),
    .outValid(bufValid),
    .outReady(bufReady),
    .outData(bufData)
  );

  dmpd_capture u_cap (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .cap(capLink.cap)
  );

  // Pins from the memory pass two flip-flops before any logic.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      syncAReg <= '0;
      syncBReg <= '0;
    end else begin
      syncAReg <= {hostReadValidIn, memStrobeIn, memDataIn};
      syncBReg <= syncAReg;
    end
  end

  // Strobe and data share the same delay, so their skew is kept.
  assign capLink.dataSync = syncBReg[W-1:0];
  assign capLink.strobeSync = syncBReg[W];
  assign capLink.validSync = syncBReg[W+1];
  assign capLink.sel72 = phaseSel72;

  // Phase counter: one lap is one memory clock period.
  assign phNext = (phReg == PH_LAST) ? '0 : phReg + PH_W'(1);
  assign clkLevelNext = (phNext < PH_HALF);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      phReg <= PH_LAST; // First lap after reset is a whole one.
    end else begin
      phReg <= phNext;
    end
  end

  // Memory and write clocks come from registers on the system clock.
  // The write strobe is built from the same counter, so its rising
  // edge lines up with the memory clock rising edge.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      memClk <= 1'b0;
      memClkN <= 1'b1;
      memWriteClock <= 1'b0;
      memWriteClockN <= 1'b1;
    end else begin
      memClk <= clkLevelNext;
      memClkN <= ~clkLevelNext;
      memWriteClock <= clkLevelNext;
      memWriteClockN <= ~clkLevelNext;
    end
  end

  // Commands are only taken at one phase of the period.
  assign takeWrite = (stateReg == ST_IDLE) && (phNext == PH_CMD) &&
    cmdValid && cmdWrite && bufValid;
  assign takeRead = (stateReg == ST_IDLE) && (phNext == PH_CMD) &&
    cmdValid && !cmdWrite;
  assign bufReady = takeWrite;

  // A write ends when the rising phase returns after its beat.
  assign writeDone = (stateReg == ST_WRITE) && launchedReg &&
    (phNext == PH_RISE);

  // With a free-running read clock, only marked pairs count as data.
  assign readHit = (stateReg == ST_READ) && capLink.pairValid &&
    (capLink.pairQual || !modeReadClock);
  assign readLate = (stateReg == ST_READ) &&
    (waitReg == WAIT_W'(READ_WAIT));

  // Sequencer next state.
  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      ST_IDLE: begin
        if (takeWrite) begin
          stateNext = ST_WRITE;
        end else if (takeRead) begin
          stateNext = ST_READ;
        end
      end
      ST_WRITE: begin
        if (writeDone) begin
          stateNext = ST_IDLE;
        end
      end
      ST_READ: begin
        if (readHit || readLate) begin
          stateNext = ST_IDLE;
        end
      end
      default: begin
        stateNext = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stateReg <= ST_IDLE;
    end else begin
      stateReg <= stateNext;
    end
  end

  // Command stage holds for a full memory period around its rising edge.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cmdStageReg <= CMD_NOP;
      addrStageReg <= '0;
      cmdAccept <= 1'b0;
    end else begin
      cmdAccept <= takeWrite || takeRead;
      if (takeWrite) begin
        cmdStageReg <= CMD_WRITE;
        addrStageReg <= cmdAddr;
      end else if (takeRead) begin
        cmdStageReg <= CMD_READ;
        addrStageReg <= cmdAddr;
      end else if (phNext == PH_CMD) begin
        cmdStageReg <= CMD_NOP;
      end
    end
  end

  // Launch on the falling edge: the memory's window is symmetrical, so
  // a half-cycle shift puts the pins in the middle of it.
  always_ff @(negedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      memCmd <= CMD_NOP;
      memAddr <= '0;
    end else begin
      memCmd <= cmdStageReg;
      memAddr <= addrStageReg;
    end
  end

  // Write beat: the rising word goes out a quarter period before the
  // strobe rises and the falling word a quarter before it falls. This
  // stands for the minus ninety degree data clock in one clock domain.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      memDataOut <= '0;
      memWrData <= '0;
      memDataOe <= '0;
      memMask <= '0;
      beatRiseReg <= '0;
      maskRiseReg <= '0;
      beatFallReg <= '0;
      maskFallReg <= '0;
      launchedReg <= 1'b0;
    end else begin
      if (takeWrite) begin
        beatRiseReg <= bufData[BUF_W-1:W+2*LANES];
        maskRiseReg <= bufData[2*LANES-1:LANES];
        beatFallReg <= bufData[2*LANES+W-1:2*LANES];
        maskFallReg <= bufData[LANES-1:0];
        launchedReg <= 1'b0;
      end
      if (stateReg == ST_WRITE && !launchedReg && phNext == PH_RISE) begin
        memDataOut <= beatRiseReg;
        memWrData <= beatRiseReg;
        memMask <= maskRiseReg;
        memDataOe <= {LANES{~modeSeparate}};
        launchedReg <= 1'b1;
      end else if (stateReg == ST_WRITE && phNext == PH_FALL) begin
        memDataOut <= beatFallReg;
        memWrData <= beatFallReg;
        memMask <= maskFallReg;
      end else if (writeDone || stateReg != ST_WRITE) begin
        memDataOe <= '0;
        memMask <= '0;
      end
    end
  end

  // Strobe: zero-phase timing, driven only across a write beat.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      memStrobeOut <= 1'b0;
      memStrobeOe <= 1'b0;
      strobeComplementOut <= 1'b1;
      strobeComplementOe <= 1'b0;
    end else begin
      if (modeReadClock || stateNext != ST_WRITE) begin
        memStrobeOe <= 1'b0;
        strobeComplementOe <= 1'b0;
        memStrobeOut <= 1'b0;
        strobeComplementOut <= 1'b1;
      end else if (launchedReg || phNext == PH_RISE) begin
        memStrobeOe <= 1'b1;
        strobeComplementOe <= 1'b1;
        memStrobeOut <= launchedReg && clkLevelNext;
        strobeComplementOut <= ~(launchedReg && clkLevelNext);
      end
    end
  end

  // Read wait counter and read result.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      waitReg <= '0;
      rdValid <= 1'b0;
      rdTimeout <= 1'b0;
      rdRise <= '0;
      rdFall <= '0;
    end else begin
      rdValid <= readHit;
      rdTimeout <= readLate && !readHit;
      if (stateReg == ST_READ) begin
        waitReg <= waitReg + WAIT_W'(1);
      end else begin
        waitReg <= '0;
      end
      if (readHit) begin
        rdRise <= capLink.riseWord;
        rdFall <= capLink.fallWord;
      end
    end
  end
endmodule : dmpd_top
